// ==== hw/phase_overcurrent_directional.sv ====
// Phase time/instant overcurrent and per-phase directional elements
// How it works
// - Definite time operates after multiplier seconds
// - Table time scaled by multiplier, reset likewise
// - Time element input: fundamental or RMS
// - Blocked accumulator decays, instant reset clears
// - Voltage restraint scales pickup by line voltage
// - Instant element on fundamental, optional delay
// - Three directional outputs, one per phase
// - Memorized polarizing voltage valid one second
// - ABC rotation polarizes with BC, CA, AB
// - ACB rotation polarizes with CB, AC, BA
// - Output zero when disabled or low current
// - Within plus/minus 90 degrees gives zero
// - Memory expired: block or permit by setting
// - Normal decisions resume when voltage returns
// - Source select picks current and quadrature voltage
// - Polarizing angle rotated leading by characteristic angle
// - Blocking input high blocks the element
// - Polarizing voltage threshold, default 0.05 pu
//
// The placing of the registers and the plain strobed port were left to the implementer.
module phase_overcurrent_directional #(
  parameter int TICK_CYCLES = phase_oc_pkg::TICK_CYC
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_ce,
  input  wire logic                     i_pass,
  input  wire phase_oc_pkg::meas_t [2:0] i_src0,
  input  wire phase_oc_pkg::meas_t [2:0] i_src1,
  input  wire logic [2:0]               i_toc_block,
  input  wire logic [2:0]               i_ioc_block,
  input  wire logic [3:0]               i_addr,
  input  wire logic [15:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic [15:0]                   o_rdata,
  output logic [2:0]                    o_toc_pickup,
  output logic [2:0]                    o_toc_op,
  output logic [2:0]                    o_ioc_op,
  output logic [2:0]                    o_dir_block,
  output logic [2:0]                    o_mem_expired
);

  localparam int TW = $clog2(TICK_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  phase_oc_pkg::ctrl_t ctrl_r;
  logic [15:0] toc_pu_r, tdm_r, ioc_pu_r, ioc_dl_r, angle_r, vthr_r, rdata_r;
  logic [15:0] tbl_r [phase_oc_pkg::TBL_N];
  logic [15:0] wr_sel;
  logic [15:0] rd_mux;
  logic [15:0] tdm_nxt;
  logic [15:0] status_w;

  assign wr_sel   = i_wr ? (16'h0001 << i_addr) : 16'h0000;
  assign tdm_nxt  = (i_wdata > phase_oc_pkg::TDM_MAX) ? phase_oc_pkg::TDM_MAX : i_wdata;
  assign status_w = {1'b0, o_mem_expired, o_dir_block, o_ioc_op, o_toc_op, o_toc_pickup};
  assign rd_mux   = i_addr[3]                          ? tbl_r[i_addr[2:0]] :
                    (i_addr == phase_oc_pkg::REG_CTRL)   ? ctrl_r   :
                    (i_addr == phase_oc_pkg::REG_TOC_PU) ? toc_pu_r :
                    (i_addr == phase_oc_pkg::REG_TDM)    ? tdm_r    :
                    (i_addr == phase_oc_pkg::REG_IOC_PU) ? ioc_pu_r :
                    (i_addr == phase_oc_pkg::REG_IOC_DL) ? ioc_dl_r :
                    (i_addr == phase_oc_pkg::REG_ANGLE)  ? angle_r  :
                    (i_addr == phase_oc_pkg::REG_VTHR)   ? vthr_r   : status_w;
  assign o_rdata  = rdata_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_r   <= phase_oc_pkg::CTRL_RST;
      toc_pu_r <= phase_oc_pkg::PU_ONE;
      tdm_r    <= phase_oc_pkg::TDM_RST;
      ioc_pu_r <= phase_oc_pkg::PU_ONE;
      ioc_dl_r <= phase_oc_pkg::DLY_RST;
      angle_r  <= phase_oc_pkg::ANGLE_RST;
      vthr_r   <= phase_oc_pkg::VTHR_RST;
      rdata_r  <= 16'h0000;
      for (int k = 0; k < phase_oc_pkg::TBL_N; k++) tbl_r[k] <= phase_oc_pkg::TBL_RST;
    end else if (i_ce) begin
      if (wr_sel[phase_oc_pkg::REG_CTRL])   ctrl_r   <= i_wdata;
      if (wr_sel[phase_oc_pkg::REG_TOC_PU]) toc_pu_r <= i_wdata;
      if (wr_sel[phase_oc_pkg::REG_TDM])    tdm_r    <= tdm_nxt;
      if (wr_sel[phase_oc_pkg::REG_IOC_PU]) ioc_pu_r <= i_wdata;
      if (wr_sel[phase_oc_pkg::REG_IOC_DL]) ioc_dl_r <= i_wdata;
      if (wr_sel[phase_oc_pkg::REG_ANGLE])  angle_r  <= i_wdata;
      if (wr_sel[phase_oc_pkg::REG_VTHR])   vthr_r   <= i_wdata;
      for (int k = 0; k < phase_oc_pkg::TBL_N; k++)
        if (wr_sel[phase_oc_pkg::REG_TBL + k]) tbl_r[k] <= i_wdata;
      rdata_r <= i_rd ? rd_mux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 10 ms timer step
  logic [TW-1:0] tick_cnt_r;
  logic          tick;

  assign tick = i_ce && (tick_cnt_r == TW'(TICK_CYCLES - 1));

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) tick_cnt_r <= '0;
    else if (i_ce) tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase comparisons
  phase_oc_pkg::meas_t [2:0] src;
  logic [15:0] iq [3], eff_pu [3], pol_live [3], pol_ang [3], diff [3];
  logic [31:0] target [3];
  logic [7:0]  incr [3];
  logic [2:0]  above, below, vok, cur_ok, outside, toc_blk, ioc_blk, ioc_above;
  logic [2:0]  bk [3];
  logic [15:0] mem_ang_r [3];

  assign src = ctrl_r.src_sel ? i_src1 : i_src0;

  for (genvar p = 0; p < 3; p++) begin : g_cmp
    localparam int Q = (p + 1) % 3;  // Quadrature line voltage
    logic [15:0] mvr;
    logic [31:0] pu_prod;
    assign iq[p]      = ctrl_r.toc_rms ? src[p].rms : src[p].fund;
    assign mvr        = (src[p].vmag >= phase_oc_pkg::PU_ONE) ? phase_oc_pkg::PU_ONE :
                        (src[p].vmag < phase_oc_pkg::MVR_MIN) ? phase_oc_pkg::MVR_MIN :
                        src[p].vmag;
    assign pu_prod    = 32'(toc_pu_r) * 32'(mvr);
    assign eff_pu[p]  = ctrl_r.vr_en ? pu_prod[phase_oc_pkg::PU_SHIFT +: 16] : toc_pu_r;
    assign above[p]   = ctrl_r.curve_tbl ? (iq[p] >= eff_pu[p]) : (iq[p] > eff_pu[p]);
    assign below[p]   = (24'(iq[p]) * 24'(phase_oc_pkg::RST_DEN))
                        <= (24'(eff_pu[p]) * 24'(phase_oc_pkg::RST_NUM));
    assign incr[p]    = ctrl_r.curve_tbl ? phase_oc_pkg::TBL_INCR : phase_oc_pkg::DEF_INCR;
    assign target[p]  = ctrl_r.curve_tbl ? 32'(tdm_r) * 32'(tbl_r[bk[p]]) : 32'(tdm_r);
    assign toc_blk[p] = i_toc_block[p] | ~ctrl_r.toc_en;
    assign ioc_blk[p] = i_ioc_block[p] | ~ctrl_r.ioc_en;
    assign ioc_above[p] = src[p].fund > ioc_pu_r;
    // Opposite rotation swaps the line voltage, i.e. adds half a turn
    assign pol_live[p] = src[Q].vang + (ctrl_r.acb ? phase_oc_pkg::HALF_TURN : 16'h0000);
    assign vok[p]     = src[Q].vmag > vthr_r;
    assign cur_ok[p]  = src[p].fund >= phase_oc_pkg::CUR_MIN;
    assign pol_ang[p] = (vok[p] ? pol_live[p] : mem_ang_r[p]) + angle_r;
    assign diff[p]    = src[p].iang - pol_ang[p];
    assign outside[p] = diff[p][15] ^ diff[p][14];

    always_comb begin
      bk[p] = 3'h0;
      for (int k = 1; k < phase_oc_pkg::TBL_N; k++)
        if ({6'h00, iq[p], 2'b00} >= 24'(eff_pu[p]) * 24'(phase_oc_pkg::RATIO_Q[k]))
          bk[p] = 3'(k);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers and decisions
  logic [31:0] acc_r [3], acc_nxt [3];
  logic [15:0] ioc_cnt_r [3], ioc_cnt_nxt [3];
  logic [7:0]  mem_cnt_r [3];
  logic [2:0]  above_r, below_r, ioc_above_r, dir_nxt;

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      acc_nxt[p] = acc_r[p];
      if ((toc_blk[p] || below_r[p]) && ctrl_r.toc_inst)
        acc_nxt[p] = 32'h0;
      else if (tick && (toc_blk[p] || below_r[p]))
        acc_nxt[p] = (acc_r[p] > 32'(incr[p])) ? acc_r[p] - 32'(incr[p]) : 32'h0;
      else if (tick && above_r[p] && acc_r[p] < target[p])
        acc_nxt[p] = acc_r[p] + 32'(incr[p]);
      ioc_cnt_nxt[p] = ioc_cnt_r[p];
      if (ioc_blk[p] || !ioc_above_r[p])
        ioc_cnt_nxt[p] = 16'h0000;
      else if (tick && ioc_cnt_r[p] != 16'hffff)
        ioc_cnt_nxt[p] = ioc_cnt_r[p] + 16'h0001;
      if (!ctrl_r.dir_en || !cur_ok[p])
        dir_nxt[p] = 1'b0;
      else if (vok[p] || mem_cnt_r[p] != 8'h00)
        dir_nxt[p] = outside[p];
      else
        dir_nxt[p] = ctrl_r.blk_exp;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      above_r       <= 3'h0;
      below_r       <= 3'h0;
      ioc_above_r   <= 3'h0;
      o_dir_block   <= 3'h0;
      o_mem_expired <= 3'h0;
      o_toc_op      <= 3'h0;
      o_toc_pickup  <= 3'h0;
      o_ioc_op      <= 3'h0;
      for (int p = 0; p < 3; p++) begin
        acc_r[p]     <= 32'h0;
        ioc_cnt_r[p] <= 16'h0000;
        mem_ang_r[p] <= 16'h0000;
        mem_cnt_r[p] <= 8'h00;
      end
    end else if (i_ce) begin
      if (i_pass) begin
        above_r       <= above;
        below_r       <= below;
        ioc_above_r   <= ioc_above;
        o_dir_block   <= dir_nxt;
        o_mem_expired <= ~vok & {mem_cnt_r[2] == 8'h00, mem_cnt_r[1] == 8'h00,
                                 mem_cnt_r[0] == 8'h00};
      end
      for (int p = 0; p < 3; p++) begin
        acc_r[p]        <= acc_nxt[p];
        ioc_cnt_r[p]    <= ioc_cnt_nxt[p];
        o_toc_pickup[p] <= ~toc_blk[p] & above_r[p];
        o_toc_op[p]     <= ~toc_blk[p] & above_r[p] & (acc_r[p] >= target[p]);
        o_ioc_op[p]     <= ~ioc_blk[p] & ioc_above_r[p] & (ioc_cnt_r[p] >= ioc_dl_r);
        // Memory keeps the last trusted angle; it ages only while voltage is low
        if (i_pass && vok[p]) begin
          mem_ang_r[p] <= pol_live[p];
          mem_cnt_r[p] <= phase_oc_pkg::MEM_TICKS;
        end else if (tick && !vok[p] && mem_cnt_r[p] != 8'h00) begin
          mem_cnt_r[p] <= mem_cnt_r[p] - 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  dir_disabled_a: assert property (i_ce && i_pass && !ctrl_r.dir_en |=> o_dir_block == 3'h0)
    else $error("direction output high while disabled");
  dir_low_cur_a: assert property (i_ce && i_pass && !cur_ok[0] |=> !o_dir_block[0])
    else $error("direction output high with low current");
  mem_expiry_a: assert property (i_ce && i_pass && ctrl_r.dir_en && cur_ok[0] && !vok[0]
      && mem_cnt_r[0] == 8'h00 |=> o_dir_block[0] == $past(ctrl_r.blk_exp))
    else $error("expiry decision does not follow setting");
  dir_angle_a: assert property (i_ce && i_pass && ctrl_r.dir_en && cur_ok[0] && vok[0]
      |=> o_dir_block[0] == $past(outside[0]))
    else $error("direction decision wrong with good voltage");
  mem_load_a: assert property (i_ce && i_pass && vok[0] |=> mem_cnt_r[0] == 8'h64)
    else $error("voltage memory not reloaded");
  mem_hold_a: assert property (i_ce && !vok[0] |=> $stable(mem_ang_r[0]))
    else $error("memorized angle changed during collapse");
  toc_inst_clr_a: assert property (i_ce && toc_blk[0] && ctrl_r.toc_inst |=> acc_r[0] == 32'h0)
    else $error("accumulator not cleared when blocked");
  toc_op_time_a: assert property ($rose(o_toc_op[0]) |-> $past(acc_r[0]) >= $past(target[0]))
    else $error("time element operated early");
  ioc_block_a: assert property (i_ce && i_ioc_block[0] |=> !o_ioc_op[0])
    else $error("instant element operated while blocked");
  vr_off_a: assert property (i_ce && i_pass && !ctrl_r.vr_en && !ctrl_r.curve_tbl
      |=> above_r[0] == ($past(iq[0]) > $past(toc_pu_r)))
    else $error("pickup altered with restraint off");
  rms_sel_a: assert property (i_ce && i_pass && ctrl_r.toc_rms && !ctrl_r.vr_en
      && !ctrl_r.curve_tbl |=> above_r[0] == ($past(src[0].rms) > $past(toc_pu_r)))
    else $error("time element input not RMS");

  dir_block_c: cover property (i_ce && i_pass ##1 o_dir_block[0]);
  toc_op_c: cover property ($rose(o_toc_op[0]));
  ioc_op_c: cover property ($rose(o_ioc_op[0]));
  mem_exp_c: cover property ($rose(o_mem_expired[0]));

endmodule : phase_overcurrent_directional

// ==== pkg/phase_oc_pkg.sv ====
// Shared constants, register map and carrier types for the phase overcurrent block
package phase_oc_pkg;

  // Magnitudes: 1.0 pu (and CT nominal) = 16'h4000; angles: full turn = 2^16
  localparam logic [15:0] PU_ONE     = 16'h4000;
  localparam logic [15:0] CUR_MIN    = 16'h0333;  // 5% of CT nominal
  localparam logic [15:0] VTHR_RST   = 16'h0333;  // 0.05 pu
  localparam logic [15:0] MVR_MIN    = 16'h0666;  // Restraint floor, 0.1 pu
  localparam logic [15:0] HALF_TURN  = 16'h8000;  // 180 deg
  localparam int          PU_SHIFT   = 14;

  // Timing: timers step in 10 ms units
  localparam int          STEP_MS    = 10;
  localparam int          CLK_MHZ    = 250;
  localparam int          TICK_CYC   = STEP_MS * 1000 * CLK_MHZ;
  localparam int          MEM_MS     = 1000;
  localparam logic [7:0]  MEM_TICKS  = 8'(MEM_MS / STEP_MS);
  localparam logic [15:0] TDM_MAX    = 16'hea60;  // 600.00 in 0.01 steps
  localparam logic [7:0]  TBL_INCR   = 8'h64;     // Hundredths per tick
  localparam logic [7:0]  DEF_INCR   = 8'h01;

  // Reset zone: ratio <= 0.98 as I*50 <= P*49
  localparam logic [7:0]  RST_NUM    = 8'h31;
  localparam logic [7:0]  RST_DEN    = 8'h32;

  // Table breakpoints in quarters of pickup: 1, 1.5, 2, 3, 4, 6, 8, 10
  localparam int          TBL_N      = 8;
  localparam logic [7:0]  RATIO_Q [TBL_N] = '{8'h04, 8'h06, 8'h08, 8'h0c,
                                              8'h10, 8'h18, 8'h20, 8'h28};

  // Register indexes
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_TOC_PU = 4'h1;
  localparam logic [3:0]  REG_TDM    = 4'h2;
  localparam logic [3:0]  REG_IOC_PU = 4'h3;
  localparam logic [3:0]  REG_IOC_DL = 4'h4;
  localparam logic [3:0]  REG_ANGLE  = 4'h5;
  localparam logic [3:0]  REG_VTHR   = 4'h6;
  localparam logic [3:0]  REG_STATUS = 4'h7;
  localparam int          REG_TBL    = 8;

  // Reset values
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] TDM_RST    = 16'h0064;
  localparam logic [15:0] DLY_RST    = 16'h0000;
  localparam logic [15:0] ANGLE_RST  = 16'h0000;
  localparam logic [15:0] TBL_RST    = 16'h0000;

  typedef struct packed {
    logic [4:0] spare;
    logic       ioc_en;
    logic       toc_en;
    logic       curve_tbl;   // 0 definite time, 1 user table
    logic       vr_en;
    logic       toc_inst;    // 1 instantaneous reset, 0 timed
    logic       toc_rms;
    logic       src_sel;
    logic       blk_exp;
    logic       acb;
    logic       dir_en;
    logic       spare0;
  } ctrl_t;

  // One phase of one source; vmag/vang is line voltage AB, BC, CA for index 0, 1, 2
  typedef struct packed {
    logic [15:0] fund;
    logic [15:0] rms;
    logic [15:0] iang;
    logic [15:0] vmag;
    logic [15:0] vang;
  } meas_t;

endpackage : phase_oc_pkg

// ==== test/meas_chain_model.sv ====
// Measurement chain model: phasor frames and the processing pass strobe
module meas_chain_model #(
  parameter int PASS_GAP = 8
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_b,
  input  wire phase_oc_pkg::meas_t [2:0] i_set0,
  input  wire phase_oc_pkg::meas_t [2:0] i_set1,
  output phase_oc_pkg::meas_t [2:0]      o_src0,
  output phase_oc_pkg::meas_t [2:0]      o_src1,
  output logic                           o_pass
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // New frame lands one cycle ahead of the pass, so the pass never sees a half update
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r  <= 8'h00;
      o_pass <= 1'b0;
      o_src0 <= '0;
      o_src1 <= '0;
    end else begin
      cnt_r  <= (cnt_r == 8'(PASS_GAP - 1)) ? 8'h00 : cnt_r + 8'h01;
      o_pass <= (cnt_r == 8'(PASS_GAP - 2));
      if (cnt_r == 8'(PASS_GAP - 3)) begin
        o_src0 <= i_set0;
        o_src1 <= i_set1;
      end
    end
  end
endmodule : meas_chain_model

// ==== test/phase_overcurrent_directional_tb.sv ====
// Self-checking bench for the phase overcurrent and directional block
module phase_overcurrent_directional_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TICKS = 4;
  logic                     clk_sys = 1'b0;
  logic                     rst_b = 1'b0;
  logic                     pass;
  phase_oc_pkg::meas_t [2:0] src0, src1, set0, set1;
  logic [2:0]               toc_block = 3'h0;
  logic [2:0]               ioc_block = 3'h0;
  logic                     ce = 1'b1;
  logic [3:0]               addr = 4'h0;
  logic [15:0]              wdata = 16'h0000;
  logic                     wr = 1'b0;
  logic                     rd = 1'b0;
  logic [15:0]              rdata;
  logic [2:0]               toc_pickup, toc_op, ioc_op, dir_block, mem_expired;
  int                       fail_count = 0;
  int                       cmp_count = 0;
  int                       cyc = 0;
  logic [15:0]              dctl [7] = '{16'h0002, 16'h0006, 16'h0002, 16'h0002, 16'h0002,
                                         16'h0000, 16'h0012};
  logic [15:0]              dang [7] = '{16'h0000, 16'h0000, 16'h8000, 16'hd000, 16'hd001,
                                         16'h0000, 16'h0000};
  logic [2:0]               dexp [7] = '{3'h2, 3'h5, 3'h5, 3'h5, 3'h2, 3'h0, 3'h5};

  always #2 clk_sys = ~clk_sys;

  meas_chain_model i_model (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_set0(set0), .i_set1(set1),
                            .o_src0(src0), .o_src1(src1), .o_pass(pass));

  phase_overcurrent_directional #(.TICK_CYCLES(TICKS)) i_dut (
    .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_ce(ce), .i_pass(pass), .i_src0(src0),
    .i_src1(src1), .i_toc_block(toc_block), .i_ioc_block(ioc_block), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_toc_pickup(toc_pickup),
    .o_toc_op(toc_op), .o_ioc_op(ioc_op), .o_dir_block(dir_block), .o_mem_expired(mem_expired));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cyc

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic check16(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    cmp_count++;
    if (rdata !== exp) begin
      fail_count++;
      $display("mismatch at %0t: reg %0h read %h expected %h", $time, a, rdata, exp);
    end
  endtask : check16

  task automatic check3(input logic [2:0] got, input logic [2:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s is %b expected %b", $time, what, got, exp);
    end
  endtask : check3

  // Same phasors on all phases; line voltage CA sits half a turn from AB and BC
  task automatic setm(input logic [15:0] f, input logic [15:0] r, input logic [15:0] vm);
    @(posedge clk_sys);
    for (int p = 0; p < 3; p++) begin
      set0[p] <= '{fund: f, rms: r, iang: 16'h1000, vmag: vm,
                   vang: (p == 2) ? 16'h8000 : 16'h0000};
    end
  endtask : setm

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int p = 0; p < 3; p++) begin
      set0[p] = '{fund: 16'h4000, rms: 16'h1000, iang: 16'h1000, vmag: 16'h4000,
                  vang: (p == 2) ? 16'h8000 : 16'h0000};
      set1[p] = '{fund: 16'h4000, rms: 16'h1000, iang: 16'h9000, vmag: 16'h4000,
                  vang: (p == 2) ? 16'h8000 : 16'h0000};
    end
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    check16(phase_oc_pkg::REG_CTRL, phase_oc_pkg::CTRL_RST);
    check16(phase_oc_pkg::REG_TOC_PU, phase_oc_pkg::PU_ONE);
    check16(phase_oc_pkg::REG_TDM, phase_oc_pkg::TDM_RST);
    check16(phase_oc_pkg::REG_VTHR, phase_oc_pkg::VTHR_RST);
    wr_reg(phase_oc_pkg::REG_TDM, 16'hffff);
    check16(phase_oc_pkg::REG_TDM, phase_oc_pkg::TDM_MAX);
    wr_reg(phase_oc_pkg::REG_STATUS, 16'hffff);
    check16(phase_oc_pkg::REG_STATUS, 16'h0000);
    wr_reg(phase_oc_pkg::REG_TDM, 16'h0064);
    for (int k = 0; k < 7; k++) begin
      wr_reg(phase_oc_pkg::REG_CTRL, dctl[k]);
      wr_reg(phase_oc_pkg::REG_ANGLE, dang[k]);
      wait_cyc(24);
      check3(dir_block, dexp[k], "direction");
    end
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h000a);
    setm(16'h0332, 16'h1000, 16'h4000);
    wait_cyc(24);
    check3(dir_block, 3'h0, "low current");
    // Voltage collapse: memory holds the decision, then expiry applies the setting
    setm(16'h4000, 16'h1000, 16'h0100);
    wait_cyc(300);
    check3(dir_block, 3'h2, "memory");
    check3(mem_expired, 3'h0, "expired");
    wait_cyc(200);
    check3(mem_expired, 3'h7, "expired");
    check3(dir_block, 3'h7, "expiry block");
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h0002);
    wait_cyc(24);
    check3(dir_block, 3'h0, "expiry permit");
    setm(16'h4000, 16'h1000, 16'h4000);
    wait_cyc(24);
    check3(dir_block, 3'h2, "resume");
    check3(mem_expired, 3'h0, "expired");
    wr_reg(phase_oc_pkg::REG_IOC_PU, 16'h2000);
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h0400);
    wait_cyc(24);
    check3(ioc_op, 3'h7, "instant");
    @(posedge clk_sys);
    ioc_block <= 3'h1;
    wait_cyc(24);
    check3(ioc_op, 3'h6, "instant blocked");
    @(posedge clk_sys);
    ioc_block <= 3'h0;
    setm(16'h0100, 16'h1000, 16'h4000);
    wr_reg(phase_oc_pkg::REG_IOC_DL, 16'h0032);
    wait_cyc(24);
    check3(ioc_op, 3'h0, "instant low");
    setm(16'h4000, 16'h1000, 16'h4000);
    wait_cyc(120);
    check3(ioc_op, 3'h0, "instant delay");
    wait_cyc(180);
    check3(ioc_op, 3'h7, "instant delay");
    // Definite time of 1.00 s is 100 ticks
    setm(16'h0100, 16'h1000, 16'h4000);
    wr_reg(phase_oc_pkg::REG_TOC_PU, 16'h2000);
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h0240);
    wait_cyc(24);
    setm(16'h4000, 16'h1000, 16'h4000);
    wait_cyc(300);
    check3(toc_pickup, 3'h7, "pickup");
    check3(toc_op, 3'h0, "definite early");
    wait_cyc(200);
    check3(toc_op, 3'h7, "definite");
    @(posedge clk_sys);
    toc_block <= 3'h7;
    wait_cyc(24);
    check3(toc_op, 3'h0, "blocked");
    @(posedge clk_sys);
    toc_block <= 3'h0;
    wait_cyc(24);
    check3(toc_op, 3'h0, "cleared");
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h0260);
    wait_cyc(24);
    check3(toc_pickup, 3'h0, "rms input");
    setm(16'h1000, 16'h1000, 16'h1000);
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h0240);
    wait_cyc(24);
    check3(toc_pickup, 3'h0, "no restraint");
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h02c0);
    wait_cyc(24);
    check3(toc_pickup, 3'h7, "restraint");
    // Table time 3 ticks at ratio 2.25, far shorter than the definite 100 ticks
    setm(16'h0100, 16'h1000, 16'h4000);
    wr_reg(4'ha, 16'h0003);
    wr_reg(4'hb, 16'h0003);
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h0340);
    wait_cyc(24);
    setm(16'h4800, 16'h1000, 16'h4000);
    wait_cyc(48);
    check3(toc_op, 3'h7, "table");
    // Timed reset: a two-cycle block only decays, so operate returns within one tick
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h0300);
    @(posedge clk_sys);
    toc_block <= 3'h7;
    @(posedge clk_sys);
    @(posedge clk_sys);
    toc_block <= 3'h0;
    wait_cyc(8);
    check3(toc_op, 3'h7, "timed reset");
    // Enable low: the write is ignored and every output holds
    @(posedge clk_sys);
    ce <= 1'b0;
    wr_reg(phase_oc_pkg::REG_CTRL, 16'h0000);
    wait_cyc(24);
    @(posedge clk_sys);
    ce <= 1'b1;
    wait_cyc(4);
    check3(toc_op, 3'h7, "frozen");
    summarize();
  end
endmodule : phase_overcurrent_directional_tb
